/* src/tx_cfg_pkg.sv */
// Purpose: Constants and types for the transmit packet configuration bank
// Assumes: Register offsets are 6-bit serial-port addresses
// Notes:   All offsets, reset values and counts live here
package tx_cfg_pkg;
	localparam logic [5:0] A_PIN0 = 6'h02;
	localparam logic [5:0] A_THR  = 6'h03;
	localparam logic [5:0] A_MKHI = 6'h04;
	localparam logic [5:0] A_MKLO = 6'h05;
	localparam logic [5:0] A_PLEN = 6'h06;
	localparam logic [5:0] A_PCTL = 6'h08;
	localparam logic [5:0] A_ADDR = 6'h09;
	localparam logic [5:0] A_CHAN = 6'h0A;
	localparam logic [5:0] A_QUEUE = 6'h3F;
	localparam logic [7:0] RST_PIN0 = 8'h3F;
	localparam logic [7:0] RST_THR  = 8'h07;
	localparam logic [7:0] RST_MKHI = 8'hD3;
	localparam logic [7:0] RST_MKLO = 8'h91;
	localparam logic [7:0] RST_PLEN = 8'hFF;
	localparam logic [7:0] RST_PCTL = 8'h45;
	localparam logic [7:0] RST_ADDR = 8'h00;
	localparam logic [7:0] RST_CHAN = 8'h00;
	localparam logic [7:0] PCTL_MASK = 8'h7F;
	localparam int     TEMP_BIT = 7;
	localparam int     INV_BIT  = 6;
	localparam int     WHITE_BIT = 6;
	localparam int     ALT_BIT   = 3;
	localparam int     CRC_BIT   = 2;
	localparam logic [5:0] SEL_THR   = 6'h02;
	localparam logic [5:0] SEL_FRAME = 6'h06;
	localparam logic [5:0] SEL_HIZ   = 6'h2E;
	localparam logic [5:0] SEL_CLK   = 6'h3F;
	localparam logic [5:0] THR_BASE  = 6'h3D;
	localparam int     CLK_DIV   = 192;
	localparam logic [6:0] DIV_HALF = 7'(CLK_DIV / 2);
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_INIT_ALT = 16'h0000;
	localparam logic [8:0]  PN_INIT  = 9'h1FF;
	localparam logic [1:0] FMT_QUEUE = 2'h0;
	localparam logic [1:0] FMT_SSYNC = 2'h1;
	localparam logic [1:0] FMT_PN    = 2'h2;
	localparam logic [1:0] FMT_ASYNC = 2'h3;
	localparam logic [1:0] LEN_FIXED = 2'h0;
	localparam logic [1:0] LEN_VAR   = 2'h1;
	localparam logic [1:0] LEN_INF   = 2'h2;
	localparam int     Q_WIDTH = 8;
	localparam int     Q_DEPTH = 32;

	typedef struct packed {
		logic [7:0] pin0;
		logic [7:0] thr;
		logic [7:0] mkhi;
		logic [7:0] mklo;
		logic [7:0] plen;
		logic [7:0] pctl;
		logic [7:0] addr;
		logic [7:0] chan;
	} cfg_s;

	typedef struct packed {
		logic       rd;
		logic       burst;
		logic [5:0] addr;
	} spi_hdr_s;

	typedef enum logic [2:0] {
		S_IDLE, S_SYNC, S_DATA, S_CRC, S_STREAM
	} fr_state_e;
endpackage

/* src/tx_packet_config_bank.sv */
// Purpose: Configuration bank, transmit queue and packet framer
// Assumes: mclk_i is the crystal clock; serial port pins are asynchronous
// Notes:   Registers are reached only over the serial configuration port
`timescale 1ns/100ps
`default_nettype none

module tx_queue #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_i,      // Clock
	input  wire logic             rstn_i,     // Async reset, low
	input  wire logic             in_valid_i, // Write request
	output logic                  in_ready_o, // Not full
	input  wire logic [WIDTH-1:0] in_data_i,  // Write data
	output logic                  out_valid_o,// Not empty
	input  wire logic             out_ready_i,// Read accept
	output logic      [WIDTH-1:0] out_data_o, // Head word
	output logic [$clog2(DEPTH):0] count_o    // Words held
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_q;
	logic [AW:0]      rp_q;
	logic             push;
	logic             pop;

	assign count_o     = wp_q - rp_q;
	assign in_ready_o  = count_o != (AW+1)'(DEPTH);
	assign out_valid_o = wp_q != rp_q;
	assign out_data_o  = mem[rp_q[AW-1:0]];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_ready_i & out_valid_o;

	always_ff @(posedge clk_i) begin
		if (push)
			mem[wp_q[AW-1:0]] <= in_data_i;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_q + (AW+1)'(push);
			rp_q <= rp_q + (AW+1)'(pop);
		end
	end
endmodule

module tx_packet_config_bank
	import tx_cfg_pkg::*;
(
	input  wire logic        mclk_i,         // Crystal clock
	input  wire logic        rstn_i,         // Async reset, low
	input  wire logic        spi_sclk_i,     // Serial port clock
	input  wire logic        spi_csn_i,      // Serial port select, low
	input  wire logic        spi_si_i,       // Serial data in
	output logic             spi_so_o,       // Serial data out
	input  wire logic        pin0_i,         // Pin 0 level in
	output logic             pin0_o,         // Pin 0 drive level
	output logic             pin0_oe_o,      // Pin 0 drive enable
	output logic             temp_sensor_en_o, // Temp sensor on
	input  wire logic        tx_start_i,     // Start transmit pulse
	input  wire logic        tx_stop_i,      // Stop transmit pulse
	input  wire logic        tx_bit_tick_i,  // One pulse per bit
	output logic             tx_bit_o,       // Bit to modulator
	output logic             tx_active_o,    // Transmission running
	output logic             underflow_o,    // Queue ran dry
	output logic             queue_over_limit_o, // Level reached
	output logic             queue_full_o,   // Queue refuses bytes
	output logic [7:0]       station_addr_o, // Filtering address
	input  wire logic [23:0] carrier_base_word_i, // Base word
	input  wire logic [15:0] chan_spacing_i, // Channel spacing
	output logic [23:0]      carrier_word_o  // Carrier word
);
	logic       sclk_s1_q, sclk_s2_q, sclk_s3_q;
	logic       csn_s1_q, csn_s2_q, csn_s3_q;
	logic       si_s1_q, si_s2_q;
	logic       pin_s1_q, pin_s2_q;
	logic [2:0] bitc_q;
	logic [7:0] rx_sh_q;
	logic [7:0] so_sh_q;
	logic       so_q;
	logic       hdr_done_q;
	spi_hdr_s   hdr_q;
	cfg_s       cfg_q;
	logic [6:0] div_cnt_q;
	logic       clk_div_q;
	fr_state_e  st_q, st_d;
	logic [15:0] sh_q, sh_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] left_q, left_d;
	logic [15:0] crc_q, crc_d;
	logic [8:0] pn_q, pn_d;
	logic       bit_q, bit_d;
	logic       unf_q, unf_d;
	logic       pin_q, oe_q, over_q, full_q, temp_q, act_q;
	logic [7:0] saddr_q;
	logic [23:0] carrier_q;
	logic [7:0] rd_data;

	wire sclk_rise = sclk_s2_q & ~sclk_s3_q;
	wire sclk_fall = ~sclk_s2_q & sclk_s3_q;
	wire cs_act    = ~csn_s2_q;
	wire cs_start  = csn_s3_q & ~csn_s2_q;
	wire [7:0] rx_byte  = {rx_sh_q[6:0], si_s2_q};
	wire byte_done = sclk_rise & cs_act & (bitc_q == 3'h7);
	wire wr_stb    = byte_done & hdr_done_q & ~hdr_q.rd;
	wire q_push    = wr_stb & (hdr_q.addr == A_QUEUE);
	wire cfg_wr    = wr_stb & (hdr_q.addr != A_QUEUE);
	wire [5:0] rd_addr = hdr_done_q ? hdr_q.addr + 6'h01 : rx_byte[5:0];
	wire next_reg  = ~hdr_done_q | hdr_q.burst;

	wire [1:0] fmt      = cfg_q.pctl[5:4];
	wire [1:0] len_mode = cfg_q.pctl[1:0];
	wire       white_on = cfg_q.pctl[WHITE_BIT];
	wire       crc_on   = cfg_q.pctl[CRC_BIT];
	wire       alt_crc  = cfg_q.pctl[ALT_BIT];
	wire [5:0] pin_sel  = cfg_q.pin0[5:0];
	wire       pin_inv  = cfg_q.pin0[INV_BIT];
	wire       temp_on  = cfg_q.pin0[TEMP_BIT];

	logic       q_in_ready, q_out_valid, q_pop;
	logic [7:0] q_data;
	logic [5:0] q_count;

	wire [7:0] status = {1'b0, st_q != S_IDLE, q_count};
	wire [5:0] thr_level = THR_BASE - {cfg_q.thr[3:0], 2'b00};
	wire       over_d = q_count >= thr_level;
	wire       white_bit = white_on & pn_q[0];
	wire       data_bit = sh_q[15] ^ white_bit;
	wire       crc_fb = crc_q[15] ^ sh_q[15];
	wire [15:0] crc_upd = {crc_q[14:0], 1'b0} ^ (crc_fb ? CRC_POLY : '0);
	wire [8:0] pn_next = {pn_q[0] ^ pn_q[5], pn_q[8:1]};
	wire [15:0] crc_start = alt_crc ? CRC_INIT_ALT : CRC_INIT;
	wire [23:0] slot_off = 24'(cfg_q.chan * chan_spacing_i);
	wire [23:0] carrier_d = carrier_base_word_i + slot_off;
	wire       sig_sel = (pin_sel == SEL_THR)   ? over_q :
	                     (pin_sel == SEL_FRAME) ? (st_q != S_IDLE) :
	                     (pin_sel == SEL_CLK)   ? clk_div_q : 1'b0;
	wire       pin_in_mode = (fmt == FMT_SSYNC) | (fmt == FMT_ASYNC);
	wire       oe_d = (pin_sel != SEL_HIZ) & ~temp_on & ~pin_in_mode;
	wire       last_bit = tx_bit_tick_i & (cnt_q == 4'h0);
	wire       more = (len_mode == LEN_INF) ? q_out_valid : left_q != 8'h00;

	always_comb begin
		case (rd_addr)
			A_PIN0:  rd_data = cfg_q.pin0;
			A_THR:   rd_data = cfg_q.thr;
			A_MKHI:  rd_data = cfg_q.mkhi;
			A_MKLO:  rd_data = cfg_q.mklo;
			A_PLEN:  rd_data = cfg_q.plen;
			A_PCTL:  rd_data = cfg_q.pctl;
			A_ADDR:  rd_data = cfg_q.addr;
			A_CHAN:  rd_data = cfg_q.chan;
			default: rd_data = 8'h00;
		endcase
	end

	tx_queue #(
		.WIDTH(Q_WIDTH),
		.DEPTH(Q_DEPTH)
	) u_queue (
		.clk_i      (mclk_i),
		.rstn_i     (rstn_i),
		.in_valid_i (q_push),
		.in_ready_o (q_in_ready),
		.in_data_i  (rx_byte),
		.out_valid_o(q_out_valid),
		.out_ready_i(q_pop),
		.out_data_o (q_data),
		.count_o    (q_count)
	);

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{sclk_s1_q, sclk_s2_q, sclk_s3_q} <= 3'h0;
			{csn_s1_q, csn_s2_q, csn_s3_q}    <= 3'h7;
			{si_s1_q, si_s2_q, pin_s1_q, pin_s2_q} <= 4'h0;
		end else begin
			{sclk_s1_q, sclk_s2_q, sclk_s3_q} <= {spi_sclk_i, sclk_s1_q, sclk_s2_q};
			{csn_s1_q, csn_s2_q, csn_s3_q}    <= {spi_csn_i, csn_s1_q, csn_s2_q};
			{si_s1_q, si_s2_q}   <= {spi_si_i, si_s1_q};
			{pin_s1_q, pin_s2_q} <= {pin0_i, pin_s1_q};
		end
	end

	// Serial port: header byte then data bytes, bursts step the address
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bitc_q     <= 3'h0;
			rx_sh_q    <= 8'h00;
			hdr_done_q <= 1'b0;
			hdr_q      <= '0;
			so_sh_q    <= 8'h00;
			so_q       <= 1'b0;
		end else if (cs_start) begin
			bitc_q     <= 3'h0;
			hdr_done_q <= 1'b0;
			so_q       <= status[7];
			so_sh_q    <= {status[6:0], 1'b0};
		end else if (sclk_rise & cs_act) begin
			rx_sh_q <= rx_byte;
			bitc_q  <= bitc_q + 3'h1;
			if (byte_done) begin
				so_sh_q <= next_reg ? rd_data : status;
				if (!hdr_done_q) begin
					hdr_q      <= rx_byte;
					hdr_done_q <= 1'b1;
				end else if (hdr_q.burst) begin
					hdr_q.addr <= rd_addr;
				end else begin
					hdr_done_q <= 1'b0;
				end
			end
		end else if (sclk_fall & cs_act) begin
			so_q    <= so_sh_q[7];
			so_sh_q <= {so_sh_q[6:0], 1'b0};
		end
	end

	// Reserved control bit seven never stores; threshold high bits do
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg_q <= {RST_PIN0, RST_THR, RST_MKHI, RST_MKLO,
			          RST_PLEN, RST_PCTL, RST_ADDR, RST_CHAN};
		end else if (cfg_wr) begin
			case (hdr_q.addr)
				A_PIN0:  cfg_q.pin0 <= rx_byte;
				A_THR:   cfg_q.thr  <= rx_byte;
				A_MKHI:  cfg_q.mkhi <= rx_byte;
				A_MKLO:  cfg_q.mklo <= rx_byte;
				A_PLEN:  cfg_q.plen <= rx_byte;
				A_PCTL:  cfg_q.pctl <= rx_byte & PCTL_MASK;
				A_ADDR:  cfg_q.addr <= rx_byte;
				A_CHAN:  cfg_q.chan <= rx_byte;
				default: cfg_q <= cfg_q;
			endcase
		end
	end

	// Framer next state
	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		cnt_d = cnt_q;
		left_d = left_q;
		crc_d = crc_q;
		pn_d = pn_q;
		bit_d = bit_q;
		unf_d = 1'b0;
		q_pop = 1'b0;
		case (st_q)
			S_IDLE: begin
				if (tx_start_i) begin
					pn_d = PN_INIT;
					crc_d = crc_start;
					if (fmt == FMT_QUEUE) begin
						st_d = S_SYNC;
						sh_d = {cfg_q.mkhi, cfg_q.mklo};
						cnt_d = 4'hF;
					end else begin
						st_d = S_STREAM;
					end
				end
			end
			S_SYNC: begin
				if (tx_bit_tick_i) begin
					bit_d = sh_q[15];
					sh_d = {sh_q[14:0], 1'b0};
					cnt_d = cnt_q - 4'h1;
				end
				if (last_bit) begin
					q_pop = q_out_valid;
					sh_d = {q_data, 8'h00};
					cnt_d = 4'h7;
					st_d = q_out_valid ? S_DATA : S_IDLE;
					unf_d = ~q_out_valid;
					left_d = (len_mode == LEN_VAR) ? q_data :
					         cfg_q.plen - 8'h01;
				end
			end
			S_DATA, S_CRC: begin
				if (tx_bit_tick_i) begin
					bit_d = data_bit;
					pn_d = pn_next;
					sh_d = {sh_q[14:0], 1'b0};
					cnt_d = cnt_q - 4'h1;
					if (st_q == S_DATA)
						crc_d = crc_upd;
				end
				if (last_bit && st_q == S_CRC) begin
					st_d = S_IDLE;
				end else if (last_bit && more) begin
					q_pop = q_out_valid;
					sh_d = {q_data, 8'h00};
					cnt_d = 4'h7;
					left_d = left_q - 8'h01;
					st_d = q_out_valid ? S_DATA : S_IDLE;
					unf_d = ~q_out_valid;
				end else if (last_bit && crc_on && len_mode != LEN_INF) begin
					st_d = S_CRC;
					sh_d = crc_upd;
					cnt_d = 4'hF;
				end else if (last_bit) begin
					st_d = S_IDLE;
				end
			end
			S_STREAM: begin
				if (fmt == FMT_ASYNC) begin
					bit_d = pin_s2_q;
				end else if (tx_bit_tick_i) begin
					pn_d = pn_next;
					bit_d = (fmt == FMT_PN) ? pn_q[0] :
					        pin_s2_q;
				end
			end
			default: st_d = S_IDLE;
		endcase
		if (tx_stop_i && st_q != S_IDLE)
			st_d = S_IDLE;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= S_IDLE;
			sh_q <= 16'h0000;
			cnt_q <= 4'h0;
			left_q <= 8'h00;
			crc_q <= 16'h0000;
			pn_q <= PN_INIT;
			bit_q <= 1'b0;
			unf_q <= 1'b0;
			act_q <= 1'b0;
		end else begin
			st_q <= st_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			left_q <= left_d;
			crc_q <= crc_d;
			pn_q <= pn_d;
			bit_q <= bit_d;
			unf_q <= unf_d;
			act_q <= st_d != S_IDLE;
		end
	end

	// Crystal clock divided by 192 for pin 0
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_cnt_q <= 7'h00;
			clk_div_q <= 1'b0;
		end else if (div_cnt_q == DIV_HALF - 7'h01) begin
			div_cnt_q <= 7'h00;
			clk_div_q <= ~clk_div_q;
		end else begin
			div_cnt_q <= div_cnt_q + 7'h01;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_q <= 1'b0;
			oe_q <= 1'b0;
			over_q <= 1'b0;
			full_q <= 1'b0;
			temp_q <= 1'b0;
			saddr_q <= 8'h00;
			carrier_q <= 24'h000000;
		end else begin
			pin_q <= sig_sel ^ pin_inv;
			oe_q <= oe_d;
			over_q <= over_d;
			full_q <= ~q_in_ready;
			temp_q <= temp_on;
			saddr_q <= cfg_q.addr;
			carrier_q <= carrier_d;
		end
	end

	assign spi_so_o = so_q;
	assign pin0_o = pin_q;
	assign pin0_oe_o = oe_q;
	assign temp_sensor_en_o = temp_q;
	assign tx_bit_o = bit_q;
	assign tx_active_o = act_q;
	assign underflow_o = unf_q;
	assign queue_over_limit_o = over_q;
	assign queue_full_o = full_q;
	assign station_addr_o = saddr_q;
	assign carrier_word_o = carrier_q;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	wire chk_over = q_count >= 6'd61 - {cfg_q.thr[3:0], 2'b00};
	wire chk_sig = sig_sel;
	wire [23:0] chk_car = carrier_d;
	wire chk_dbit = data_bit;

	a_thr_level: assert property (chk_over |=> queue_over_limit_o)
		else $error("threshold flag missed");
	a_pin0_invert: assert property (1'b1 |=> pin0_o == ($past(chk_sig) ^ $past(pin_inv)))
		else $error("pin 0 polarity wrong");
	a_clk_div_half: assert property ($rose(clk_div_q) |-> ##96 $fell(clk_div_q))
		else $error("divided clock period wrong");
	a_marker_load: assert property (st_q == S_IDLE && tx_start_i && fmt == FMT_QUEUE && !tx_stop_i
		|=> st_q == S_SYNC && sh_q == {$past(cfg_q.mkhi), $past(cfg_q.mklo)})
		else $error("marker word not loaded");
	a_fixed_len: assert property ($past(st_q) == S_SYNC && st_q == S_DATA && $past(len_mode) == LEN_FIXED
		|-> left_q == $past(cfg_q.plen) - 8'h01)
		else $error("fixed length wrong");
	a_var_len: assert property ($past(st_q) == S_SYNC && st_q == S_DATA && $past(len_mode) == LEN_VAR
		|-> left_q == $past(q_data))
		else $error("variable length wrong");
	a_white_bit: assert property (st_q == S_DATA && tx_bit_tick_i && !tx_stop_i
		|=> tx_bit_o == $past(chk_dbit))
		else $error("whitened bit wrong");
	a_crc_skip: assert property (st_q == S_DATA && !crc_on |=> st_q != S_CRC)
		else $error("checksum sent while disabled");
	a_pn_stream: assert property (st_q == S_STREAM && fmt == FMT_PN && tx_bit_tick_i && !tx_stop_i
		|=> tx_bit_o == $past(pn_q[0]))
		else $error("random bit wrong");
	a_async_pass: assert property (st_q == S_STREAM && fmt == FMT_ASYNC && !tx_stop_i
		|=> tx_bit_o == $past(pin_s2_q))
		else $error("transparent bit wrong");
	a_carrier_word: assert property (1'b1 |=> carrier_word_o == $past(chk_car))
		else $error("carrier word wrong");

	c_crc_frame: cover property (st_q == S_CRC ##[1:1000] st_q == S_IDLE);
	c_underflow: cover property (underflow_o);
	c_queue_full: cover property (queue_full_o);
	c_pn_run: cover property (st_q == S_STREAM && fmt == FMT_PN);
endmodule

`default_nettype wire

/* test/spi_host_model.sv */
// Purpose: Host microcontroller on the serial configuration port
// Assumes: Half periods of 6 mclk, which is above the 4 mclk minimum
// Notes:   Cleans register writes the way the host is obliged to
`timescale 1ns/100ps
`default_nettype none
module spi_host_model
	import tx_cfg_pkg::*;
(
	input  wire logic mclk_i, // Device clock, paces the port
	output logic      sclk_o, // Serial clock, idle low
	output logic      csn_o,  // Select, active low
	output logic      si_o,   // Data to device
	input  wire logic so_i    // Data from device
);
	initial begin
		sclk_o = 1'b0;
		csn_o  = 1'b1;
		si_o   = 1'b0;
	end
	task automatic pace();
		repeat (6) @(negedge mclk_i);
	endtask
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			si_o = tx[i];
			pace();
			sclk_o = 1'b1;
			rx[i] = so_i;
			pace();
			sclk_o = 1'b0;
		end
	endtask
	task automatic access(input logic rd, input logic [5:0] a,
		input logic [7:0] wd, output logic [7:0] rv);
		logic [7:0] d;
		logic [7:0] st;
		d = wd;
		if (!rd && a == A_PIN0 && d[TEMP_BIT])
			d = 8'h80;
		if (!rd && a == A_THR)
			d[7:4] = 4'h0;
		csn_o = 1'b0;
		pace();
		xbyte({rd, 1'b0, a}, st);
		xbyte(d, rv);
		pace();
		csn_o = 1'b1;
		// Released data line must not keep its last level
		si_o = ~si_o;
		pace();
	endtask
	// Pin 0 to high impedance before power-down
	task automatic park();
		logic [7:0] rv;
		access(1'b0, A_PIN0, {2'b00, SEL_HIZ}, rv);
	endtask
endmodule
`default_nettype wire

/* test/tb_tx_packet_config_bank.sv */
// Purpose: Self-checking bench for the configuration bank
// Assumes: Host model drives the serial port
// Notes:   Packets are checked with whitening off and on
`timescale 1ns/100ps
`default_nettype none
module tb_tx_packet_config_bank;
	import tx_cfg_pkg::*;
	logic        mclk_i = 0, rstn_i = 0, pin0_i = 0;
	logic        start = 0, stop = 0, tick = 0;
	logic        sclk, csn, si, so, pin0_o, oe, temp, bit_o, act, full, lim;
	logic        unf, eb;
	logic [8:0]  pn;
	logic [7:0]  st_addr, rv, b;
	logic [23:0] base = 0, cw;
	logic [15:0] spc = 0;
	logic        exp_q[$], got[$];
	int          bad_count = 0, num_checks = 0, cyc = 0, n, t, unf_cnt = 0;
	logic [5:0]  ra [8] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08,
		6'h09, 6'h0A};
	logic [7:0]  rr [8] = '{8'h3F, 8'h07, 8'hD3, 8'h91, 8'hFF, 8'h45,
		8'h00, 8'h00};
	always #2 mclk_i = ~mclk_i;
	tx_packet_config_bank tx_packet_config_bank_i (.mclk_i(mclk_i),
		.rstn_i(rstn_i), .spi_sclk_i(sclk), .spi_csn_i(csn),
		.spi_si_i(si), .spi_so_o(so), .pin0_i(pin0_i), .pin0_o(pin0_o),
		.pin0_oe_o(oe), .temp_sensor_en_o(temp), .tx_start_i(start),
		.tx_stop_i(stop), .tx_bit_tick_i(tick), .tx_bit_o(bit_o),
		.tx_active_o(act), .underflow_o(unf), .queue_over_limit_o(lim),
		.queue_full_o(full), .station_addr_o(st_addr),
		.carrier_base_word_i(base), .chan_spacing_i(spc),
		.carrier_word_o(cw));
	spi_host_model spi_host_model_i (.mclk_i(mclk_i), .sclk_o(sclk),
		.csn_o(csn), .si_o(si), .so_i(so));
	task automatic check(input logic [23:0] g, input logic [23:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			conclude();
		end
	end
	// Underflow is a one-cycle pulse, so it is counted where it stands
	always @(negedge mclk_i)
		if (unf === 1'b1)
			unf_cnt++;
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		spi_host_model_i.access(1'b0, a, d, rv);
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		spi_host_model_i.access(1'b1, a, 8'h00, d);
	endtask
	task automatic pulse(ref logic s);
		@(negedge mclk_i) s = 1'b1;
		@(negedge mclk_i) s = 1'b0;
		@(negedge mclk_i);
	endtask
	task automatic wait_chg(output int c);
		logic l;
		l = pin0_o;
		c = 0;
		do begin
			@(negedge mclk_i);
			c++;
		end while (pin0_o === l && c < 300);
	endtask
	function automatic logic [7:0] wr_exp(logic [5:0] a, logic [7:0] d);
		if (a == A_PIN0 && d[7])
			return 8'h80;
		if (a == A_THR)
			return {4'h0, d[3:0]};
		if (a == A_PCTL)
			return {1'b0, d[6:0]};
		return d;
	endfunction
	function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
		return c;
	endfunction
	function automatic void put8(logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			exp_q.push_back(d[i]);
	endfunction
	task automatic packet(input logic [7:0] pc, input int cnt);
		logic [15:0] c;
		c = pc[3] ? 16'h0000 : 16'hFFFF;
		exp_q = {};
		got = {};
		wr(A_PCTL, pc);
		wr(A_PLEN, 8'(cnt));
		put8(8'hD3);
		put8(8'h91);
		if (pc[1:0] == 2'b01) begin
			wr(A_QUEUE, 8'(cnt));
			put8(8'(cnt));
			c = crc_step(c, 8'(cnt));
		end
		repeat (cnt) begin
			b = 8'($urandom);
			wr(A_QUEUE, b);
			put8(b);
			c = crc_step(c, b);
		end
		if (pc[2]) begin
			put8(c[15:8]);
			put8(c[7:0]);
		end
		pulse(start);
		check(24'(act), 24'h1);
		got.push_back(bit_o);
		foreach (exp_q[i]) begin
			pulse(tick);
			got.push_back(bit_o);
		end
		// Bits after the marker are whitened with PN9 when asked for
		pn = 9'h1FF;
		foreach (exp_q[i]) begin
			eb = exp_q[i];
			if (i >= 16) begin
				eb = eb ^ (pc[6] & pn[0]);
				pn = {pn[0] ^ pn[5], pn[8:1]};
			end
			check(24'(got[i + 1]), 24'(eb));
		end
		pulse(tick);
		check(24'(act), 24'h0);
	endtask
	initial begin
		void'($urandom(56606));
		repeat (16) @(negedge mclk_i);
		rstn_i = 1'b1;
		repeat (4) @(negedge mclk_i);
		wait_chg(t);
		wait_chg(t);
		check(24'(t), 24'd96);
		for (int i = 0; i < 8; i++) begin
			rd(ra[i], rv);
			check(24'(rv), 24'(rr[i]));
		end
		wr(A_PIN0, 8'h40);
		check(24'({pin0_o, oe}), 24'h3);
		wr(A_PIN0, 8'h00);
		check(24'({pin0_o, oe}), 24'h1);
		wr(A_PIN0, 8'hBF);
		check(24'({temp, oe}), 24'h2);
		wr(6'h07, 8'hA5);
		rd(6'h07, rv);
		check(24'(rv), 24'h0);
		for (int i = 0; i < 24; i++) begin
			n = $urandom % 8;
			b = 8'($urandom);
			wr(ra[n], b);
			rd(ra[n], rv);
			check(24'(rv), 24'(wr_exp(ra[n], b)));
		end
		// Put the marker back to the value the packets expect
		wr(A_MKHI, 8'hD3);
		wr(A_MKLO, 8'h91);
		b = 8'($urandom);
		wr(A_ADDR, b);
		check(24'(st_addr), 24'(b));
		base = 24'($urandom);
		spc = 16'($urandom);
		b = 8'($urandom);
		wr(A_CHAN, b);
		check(cw, base + b * spc);
		wr(A_PIN0, 8'h00);
		wr(A_PCTL, 8'h10);
		check(24'(oe), 24'h0);
		pulse(start);
		for (int i = 0; i < 4; i++) begin
			pin0_i = 1'($urandom);
			repeat (2) @(negedge mclk_i);
			pulse(tick);
			check(24'(bit_o), 24'(pin0_i));
		end
		pulse(stop);
		wr(A_PCTL, 8'h20);
		pulse(start);
		check(24'(act), 24'h1);
		pn = 9'h1FF;
		for (int i = 0; i < 12; i++) begin
			pulse(tick);
			check(24'(bit_o), 24'(pn[0]));
			pn = {pn[0] ^ pn[5], pn[8:1]};
		end
		pulse(stop);
		check(24'(act), 24'h0);
		wr(A_PCTL, 8'h30);
		pulse(start);
		for (int i = 0; i < 8; i++) begin
			pin0_i = 1'($urandom);
			repeat (4) @(negedge mclk_i);
			check(24'({bit_o, oe}), 24'({pin0_i, 1'b0}));
		end
		pulse(stop);
		packet(8'h04, 3);
		packet(8'h4D, 5);
		packet(8'h00, 1);
		// Start with an empty queue: marker, then underflow and stop
		check(24'(unf_cnt), 24'h0);
		pulse(start);
		repeat (16) pulse(tick);
		check(24'(unf_cnt), 24'h1);
		check(24'(act), 24'h0);
		n = 8 + $urandom % 8;
		wr(A_THR, 8'(n));
		repeat (60 - 4 * n) wr(A_QUEUE, 8'h5A);
		check(24'(lim), 24'h0);
		wr(A_QUEUE, 8'h5A);
		check(24'(lim), 24'h1);
		for (int i = 61 - 4 * n; i < 33; i++)
			wr(A_QUEUE, 8'hC3);
		check(24'(full), 24'h1);
		wr(A_PCTL, 8'h02);
		pulse(start);
		t = 0;
		while (act === 1'b1 && t < 400) begin
			pulse(tick);
			t++;
		end
		check(24'(t), 24'd272);
		check(24'({full, lim}), 24'h0);
		spi_host_model_i.park();
		check(24'(oe), 24'h0);
		conclude();
	end
endmodule
`default_nettype wire
